/* design/msp_cfg.svh */
// Constants for the multilevel port shutdown priority block.
`ifndef MSP_CFG_SVH
`define MSP_CFG_SVH

// =====================================================================
// Register map
`define MSP_CMD_PRIO_43 8'h28
`define MSP_PRIO_RESET 8'h00
`define MSP_RDATA_IDLE 8'h00

// =====================================================================
// Field layout
`define MSP_LEVEL_W 3
`define MSP_PORT3_LSB 0
`define MSP_PORT4_LSB 4
`define MSP_PORTS 2
`define MSP_LEVEL_HIGHEST 3'h0

`endif

/* design/msp_pkg.sv */
// Types shared by the multilevel port shutdown priority block.
`include "msp_cfg.svh"

package msp_pkg;

	typedef logic [`MSP_LEVEL_W-1:0] msp_level_type;
	typedef logic [7:0] msp_byte_type;
	typedef logic [`MSP_PORTS-1:0] msp_port_vec_type;

endpackage

/* design/msp_port_cmp.sv */
// Per-port comparison of a shutdown code against a priority level.
`timescale 1ns/1ns
`include "msp_cfg.svh"

module msp_port_cmp
	import msp_pkg::*;
#(
	parameter int LEVEL_WIDTH = `MSP_LEVEL_W
) (
	// Mode and level
	input wire logic multilevel_priority_select,
	input wire logic [LEVEL_WIDTH-1:0] port_priority_level,
	// Shutdown code
	input wire logic shutdown_valid,
	input wire logic [LEVEL_WIDTH-1:0] shutdown_code,
	// Decision
	output logic turn_off
);

	// A wider level would no longer match the three-bit code from the host.
	generate
		if (LEVEL_WIDTH < 1 || LEVEL_WIDTH > 3) begin : g_bad_width
			$error("msp_port_cmp: level width must be 1 to 3");
		end
	endgenerate

	// A lower level value means a higher priority, so a port falls when the
	// code does not exceed its level.
	always_comb begin
		turn_off = shutdown_valid && multilevel_priority_select &&
			(shutdown_code <= port_priority_level);
	end

endmodule

/* design/msp_shutdown_priority.sv */
// Multilevel shutdown priority logic for ports three and four.
`timescale 1ns/1ns
`include "msp_cfg.svh"

// Functional notes
// - Each port keeps a three-bit priority level that matters only while multilevel select is high.
// - Level 000 is the highest priority and priority falls as the level value rises.
// - The shutdown code taken from the fast-shutdown input decides which ports turn off.
// - A port whose level is at or above the received code is powered off.
// - A port whose level is below the received code keeps its power state.
// - A priority turn-off clears port bits like a port reset but never aborts a cool-down count.
// - Levels for ports three and four share byte 28h, bits 2:0 and 6:4, read/write, reset zero.
module msp_shutdown_priority
	import msp_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register command port
	input wire logic [7:0] cmd_code,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_wdata,
	input wire logic cmd_read,
	output logic [7:0] cmd_rdata,
	output logic cmd_rvalid,
	// Mode from the general mask register
	input wire logic multilevel_priority_select,
	// Deserialised shutdown code
	input wire logic shutdown_valid,
	input wire logic [`MSP_LEVEL_W-1:0] shutdown_code,
	// Port control, index 0 is port three and index 1 is port four
	input wire logic [`MSP_PORTS-1:0] port_reset_cmd,
	input wire logic [`MSP_PORTS-1:0] cooldown_active,
	output logic [`MSP_PORTS-1:0] port_off,
	output logic [`MSP_PORTS-1:0] port_clear,
	output logic [`MSP_PORTS-1:0] cooldown_abort,
	output logic [`MSP_PORTS*`MSP_LEVEL_W-1:0] port_priority_level
);

	// =====================================================================
	// Command decode

	function automatic logic hits_prio(input logic [7:0] code);
		hits_prio = (code == `MSP_CMD_PRIO_43);
	endfunction

	// =====================================================================
	// Priority register

	msp_byte_type prio_reg;
	msp_byte_type next_prio_reg;
	msp_byte_type next_cmd_rdata;
	logic next_cmd_rvalid;

	always_comb begin
		next_prio_reg = prio_reg;
		if (cmd_write && hits_prio(cmd_code)) begin
			next_prio_reg = cmd_wdata;
		end
		next_cmd_rdata = `MSP_RDATA_IDLE;
		next_cmd_rvalid = 1'b0;
		if (cmd_read && hits_prio(cmd_code)) begin
			next_cmd_rdata = prio_reg;
			next_cmd_rvalid = 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prio_reg <= `MSP_PRIO_RESET;
			cmd_rdata <= `MSP_RDATA_IDLE;
			cmd_rvalid <= 1'b0;
		end else begin
			prio_reg <= next_prio_reg;
			cmd_rdata <= next_cmd_rdata;
			cmd_rvalid <= next_cmd_rvalid;
		end
	end

	// Unused bits 3 and 7 are stored as written so that readback matches.
	msp_level_type level [`MSP_PORTS];

	always_comb begin
		level[0] = prio_reg[`MSP_PORT3_LSB +: `MSP_LEVEL_W];
		level[1] = prio_reg[`MSP_PORT4_LSB +: `MSP_LEVEL_W];
		port_priority_level = {level[1], level[0]};
	end

	// =====================================================================
	// Shutdown decision

	msp_port_vec_type cmp_off;

	genvar gi;
	generate
		for (gi = 0; gi < `MSP_PORTS; gi++) begin : g_port
			msp_port_cmp #(
				.LEVEL_WIDTH(`MSP_LEVEL_W)
			) u_cmp (
				.multilevel_priority_select(multilevel_priority_select),
				.port_priority_level(level[gi]),
				.shutdown_valid(shutdown_valid),
				.shutdown_code(shutdown_code),
				.turn_off(cmp_off[gi])
			);
		end
	endgenerate

	// =====================================================================
	// Port control outputs

	msp_port_vec_type next_port_off;
	msp_port_vec_type next_port_clear;
	msp_port_vec_type next_cooldown_abort;

	// A priority turn-off reuses the port reset clearing path, but only a
	// real reset command may stop a running cool-down; otherwise a faulted
	// port could be re-powered early by a host merely shedding load.
	always_comb begin
		next_port_off = cmp_off;
		next_port_clear = cmp_off | port_reset_cmd;
		next_cooldown_abort = port_reset_cmd & cooldown_active;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			port_off <= '0;
			port_clear <= '0;
			cooldown_abort <= '0;
		end else begin
			port_off <= next_port_off;
			port_clear <= next_port_clear;
			cooldown_abort <= next_cooldown_abort;
		end
	end

	// =====================================================================
	// Assertions

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	sequence s_code_for_port3_le;
		shutdown_valid && multilevel_priority_select &&
			(shutdown_code <= prio_reg[`MSP_PORT3_LSB +: `MSP_LEVEL_W]);
	endsequence

	sequence s_code_for_port4_gt;
		shutdown_valid && multilevel_priority_select &&
			(shutdown_code > prio_reg[`MSP_PORT4_LSB +: `MSP_LEVEL_W]);
	endsequence

	sequence s_prio_off_only;
		(port_reset_cmd == '0) && (cmp_off != '0);
	endsequence

	sequence s_reset_in_cooldown;
		(port_reset_cmd & cooldown_active) != '0;
	endsequence

	property p_level_write;
		cmd_write && hits_prio(cmd_code) |=>
			port_priority_level == {$past(cmd_wdata[6:4]), $past(cmd_wdata[2:0])};
	endproperty
	a_level_write: assert property (p_level_write) else $error("level write lost");

	property p_highest_level;
		shutdown_valid && multilevel_priority_select &&
			(prio_reg[`MSP_PORT3_LSB +: `MSP_LEVEL_W] == `MSP_LEVEL_HIGHEST) &&
			(shutdown_code != `MSP_LEVEL_HIGHEST) |=> !port_off[0];
	endproperty
	a_highest_level: assert property (p_highest_level) else $error("top level port shut");

	property p_no_code_no_off;
		!shutdown_valid |=> port_off == '0;
	endproperty
	a_no_code_no_off: assert property (p_no_code_no_off) else $error("off without code");

	property p_off_when_le;
		s_code_for_port3_le |=> port_off[0] && port_clear[0];
	endproperty
	a_off_when_le: assert property (p_off_when_le) else $error("port three not shut");

	property p_keep_when_gt;
		s_code_for_port4_gt |=> !port_off[1];
	endproperty
	a_keep_when_gt: assert property (p_keep_when_gt) else $error("port four shut");

	property p_no_cooldown_abort;
		s_prio_off_only |=> (cooldown_abort == '0) && (port_clear == port_off);
	endproperty
	a_no_cooldown_abort: assert property (p_no_cooldown_abort) else $error("cool-down cut");

	// Reads of any other command code must stay silent on this port.
	property p_readback;
		cmd_read && !hits_prio(cmd_code) |=> !cmd_rvalid && (cmd_rdata == `MSP_RDATA_IDLE);
	endproperty
	a_readback: assert property (p_readback) else $error("readback wrong");

	property p_rvalid_pulse;
		!cmd_read |=> !cmd_rvalid;
	endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("stray read valid");

	property p_abort_from_reset;
		s_reset_in_cooldown |=>
			cooldown_abort == ($past(port_reset_cmd) & $past(cooldown_active));
	endproperty
	a_abort_from_reset: assert property (p_abort_from_reset) else $error("no abort");

	property p_clear_on_reset;
		port_reset_cmd != '0 |=> (port_clear & $past(port_reset_cmd)) == $past(port_reset_cmd);
	endproperty
	a_clear_on_reset: assert property (p_clear_on_reset) else $error("reset clear lost");

	property p_read_value;
		cmd_read && hits_prio(cmd_code) |=> cmd_rvalid && cmd_rdata == $past(prio_reg);
	endproperty
	a_read_value: assert property (p_read_value) else $error("read data wrong");

	property p_mode_off;
		!multilevel_priority_select |=> port_off == '0;
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("shut in single mode");

endmodule

/* test/msp_host_model.sv */
// Host model that drives the deserialised shutdown code into the device.
`timescale 1ns/1ns

module msp_host_model import msp_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Request from the bench
	input wire logic go,
	input wire logic [2:0] code_in,
	// Shutdown code toward the device
	output logic shutdown_valid,
	output msp_level_type shutdown_code
);
	// ===================================================================
	// Code driver
	logic next_valid;
	msp_level_type next_code;

	// The code line toggles while idle, so a device that samples it without valid is caught.
	always_comb begin
		next_valid = go;
		next_code = go ? code_in : ~shutdown_code;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			shutdown_valid <= 1'b0;
			shutdown_code <= 3'h0;
		end else begin
			shutdown_valid <= next_valid;
			shutdown_code <= next_code;
		end
	end
endmodule

/* test/tb.sv */
// Self-checking testbench for the multilevel shutdown priority block.
`timescale 1ns/1ns
`include "msp_cfg.svh"

module tb import msp_pkg::*;;
	// ===================================================================
	// Signals
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] cmd_code = 8'h00;
	logic [7:0] cmd_wdata = 8'h00;
	logic cmd_write = 1'b0;
	logic cmd_read = 1'b0;
	logic sel = 1'b0;
	logic go = 1'b0;
	logic [2:0] code_in = 3'h0;
	msp_port_vec_type rcmd = 2'b00;
	msp_port_vec_type cool = 2'b00;
	logic [7:0] rdata;
	logic rvalid;
	logic svalid;
	msp_level_type scode;
	msp_port_vec_type off, clr, abort;
	logic [5:0] lvl;
	int bad_count = 0;
	int check_count = 0;

	always #2 clock = ~clock;

	msp_host_model host (.clock(clock), .rst(rst), .go(go), .code_in(code_in),
		.shutdown_valid(svalid), .shutdown_code(scode));
	msp_shutdown_priority uut (.clock(clock), .rst(rst), .cmd_code(cmd_code),
		.cmd_write(cmd_write), .cmd_wdata(cmd_wdata), .cmd_read(cmd_read),
		.cmd_rdata(rdata), .cmd_rvalid(rvalid), .multilevel_priority_select(sel),
		.shutdown_valid(svalid), .shutdown_code(scode), .port_reset_cmd(rcmd),
		.cooldown_active(cool), .port_off(off), .port_clear(clr),
		.cooldown_abort(abort), .port_priority_level(lvl));

	// ===================================================================
	// Shared tasks
	task chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input msp_byte_type d);
		@(posedge clock);
		cmd_code <= 8'h28;
		cmd_write <= 1'b1;
		cmd_wdata <= d;
		@(posedge clock);
		cmd_write <= 1'b0;
		#1;
		chk(8'(lvl), {2'b00, d[6:4], d[2:0]});
	endtask

	task rd(input msp_byte_type c, input msp_byte_type e, input logic v);
		@(posedge clock);
		cmd_code <= c;
		cmd_read <= 1'b1;
		@(posedge clock);
		cmd_read <= 1'b0;
		#1;
		chk(8'(rvalid), 8'(v));
		chk(rdata, e);
		@(posedge clock);
		#1;
		chk(8'(rvalid), 8'h00);
		chk(rdata, 8'h00);
	endtask

	task shd(input logic [2:0] c, input logic s, input msp_port_vec_type cl);
		@(posedge clock);
		go <= 1'b1;
		code_in <= c;
		sel <= s;
		cool <= cl;
		@(posedge clock);
		go <= 1'b0;
		@(posedge clock);
		#1;
	endtask

	// ===================================================================
	// Scenarios
	task t_reset;
		chk(8'(lvl), 8'h00);
		rd(8'h28, 8'h00, 1'b1);
	endtask

	task t_regs;
		wr(8'hD9);
		rd(8'h28, 8'hD9, 1'b1);
		rd(8'h27, 8'h00, 1'b0);
	endtask

	task t_levels;
		msp_byte_type d;
		msp_port_vec_type e;
		for (int i = 0; i < 2; i++) begin
			d = i ? 8'h70 : 8'hD9;
			wr(d);
			for (int c = 0; c < 8; c++) begin
				shd(3'(c), 1'b1, 2'b11);
				e = {3'(c) <= d[6:4], 3'(c) <= d[2:0]};
				chk(8'(off), 8'(e));
				chk(8'(clr), 8'(e));
				chk(8'(abort), 8'h00);
			end
		end
	endtask

	task t_disabled;
		shd(3'h0, 1'b0, 2'b00);
		chk(8'(off), 8'h00);
		chk(8'(clr), 8'h00);
	endtask

	task t_port_reset;
		@(posedge clock);
		rcmd <= 2'b10;
		cool <= 2'b10;
		@(posedge clock);
		rcmd <= 2'b00;
		#1;
		chk(8'(clr), 8'h02);
		chk(8'(abort), 8'h02);
		chk(8'(off), 8'h00);
		@(posedge clock);
		rcmd <= 2'b01;
		cool <= 2'b00;
		@(posedge clock);
		rcmd <= 2'b00;
		#1;
		chk(8'(clr), 8'h01);
		chk(8'(abort), 8'h00);
	endtask

	// A read and a write on the same edge must return the old byte.
	task t_order;
		@(posedge clock);
		cmd_code <= 8'h28;
		cmd_write <= 1'b1;
		cmd_read <= 1'b1;
		cmd_wdata <= 8'h51;
		@(posedge clock);
		cmd_write <= 1'b0;
		cmd_read <= 1'b0;
		#1;
		chk(rdata, 8'h70);
		chk(8'(lvl), 8'h29);
	endtask

	task t_mid_reset;
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		#1;
		chk(8'(lvl), 8'h00);
		rd(8'h28, 8'h00, 1'b1);
	endtask

	// ===================================================================
	// Run control
	task test_done;
		if (bad_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		t_reset;
		t_regs;
		t_levels;
		t_disabled;
		t_port_reset;
		t_order;
		t_mid_reset;
		test_done;
	end

	// A hang ends the run as a failure rather than stalling forever.
	initial begin
		repeat (3000) @(posedge clock);
		bad_count++;
		test_done;
	end
endmodule
